// ---- design/rssf_pkg.sv ----
// package for the reset state and source flag block: register indices,
// reset values, flag positions and the carrier types.
// assumes a single 40 MHz system clock domain and byte-wide registers.
package rssf_pkg;

   // number of peripheral registers forced by every reset
   localparam int NUM_REGS = 55;

   // register indices inside the peripheral bank
   localparam int IDX_CLK_OUT_SEL = 0;
   localparam int IDX_WDT_ENABLE = 1;
   localparam int IDX_ADC_RES_LO = 2;
   localparam int IDX_ADC_RES_HI = 3;
   localparam int IDX_ADC_CFG_B = 9;
   localparam int IDX_RX_BUF = 12;
   localparam int IDX_TX_BUF = 13;
   localparam int IDX_AS_MODE = 14;
   localparam int IDX_BAUD_CTRL = 18;
   localparam int IDX_AS_CTRL = 19;
   localparam int IDX_TW_LOW = 34;
   localparam int IDX_TW_HIGH = 35;
   localparam int IDX_IRQ_REQ = 38;
   localparam int IDX_IRQ_MASK = 42;
   localparam int IDX_IRQ_PRIO = 46;
   localparam int IRQ_GROUP = 4;
   localparam int IDX_REG_MODE = 54;
   // detector registers, written through the same port, reset by source
   localparam int IDX_LVI_CTRL = 55;
   localparam int IDX_LVI_LEVEL = 56;

   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_ONES = 8'hFF;
   localparam logic [7:0] RST_WDT_EN_A = 8'h1A;
   localparam logic [7:0] RST_WDT_EN_B = 8'h9A;
   localparam logic [7:0] RST_ADC_CFG_B = 8'h07;
   localparam logic [7:0] RST_AS_MODE = 8'h01;
   localparam logic [7:0] RST_AS_CTRL = 8'h16;

   // bit positions in the source flag byte
   localparam int FLAG_WDT_BIT = 4;
   localparam int FLAG_LVI_BIT = 0;

   typedef logic [NUM_REGS-1:0][7:0] rssf_bank_t;

   // one software write
   typedef struct packed {
      logic en;
      logic [5:0] idx;
      logic [7:0] data;
   } rssf_wr_t;

   // detector settings
   typedef struct packed {
      logic [7:0] control;
      logic [7:0] level;
   } rssf_lvi_t;

endpackage

// ---- design/rssf_top.sv ----
// reset state and source flag block: holds the peripheral bank, the
// source flags and the detector settings and forces their reset values.
// assumes all request lines except the pin reset come from I_CLK logic.
// the option and package inputs are static straps, so they pass no synchroniser.
// writes and flag reads are ignored while any request is high.
`timescale 1ns/100ps
`default_nettype none
module rssf_top
   import rssf_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RESET_N,
   input wire logic i_pin_reset_n,
   input wire logic i_wdt_reset_req,
   input wire logic i_lvi_reset_req,
   input wire logic i_lvi_default_reset_req,
   input wire logic i_wdt_option,
   input wire logic i_package_32pin,
   input wire rssf_wr_t i_write,
   input wire logic i_flags_read,
   output logic o_in_reset,
   output var rssf_bank_t o_regs,
   output logic [7:0] o_reset_source_flags,
   output var rssf_lvi_t o_lvi
);

   // reset value of one bank register
   function automatic logic [7:0] rst_val(input int idx, input logic wdt_opt, input logic pkg32);
      logic [7:0] v;
      v = RST_ZERO;
      if (idx == IDX_WDT_ENABLE) begin
         v = wdt_opt ? RST_WDT_EN_B : RST_WDT_EN_A;
      end else if (idx == IDX_ADC_CFG_B) begin
         v = pkg32 ? RST_ZERO : RST_ADC_CFG_B;
      end else if (idx == IDX_AS_MODE) begin
         v = RST_AS_MODE;
      end else if (idx == IDX_AS_CTRL) begin
         v = RST_AS_CTRL;
      end else if (idx == IDX_RX_BUF || idx == IDX_TX_BUF) begin
         v = RST_ONES;
      end else if (idx == IDX_BAUD_CTRL) begin
         v = RST_ONES;
      end else if (idx == IDX_TW_LOW || idx == IDX_TW_HIGH) begin
         v = RST_ONES;
      end else if (idx >= IDX_IRQ_MASK && idx < IDX_IRQ_MASK + IRQ_GROUP) begin
         v = RST_ONES;
      end else if (idx >= IDX_IRQ_PRIO && idx < IDX_IRQ_PRIO + IRQ_GROUP) begin
         v = RST_ONES;
      end
      return v;
   endfunction

   // pin reset synchroniser
   logic pin_meta_r;
   logic pin_sync_r;
   logic pin_meta_nxt;
   logic pin_sync_nxt;

   always_comb begin
      pin_meta_nxt = ~i_pin_reset_n;
      pin_sync_nxt = pin_meta_r;
      if (!I_RESET_N) begin
         pin_meta_nxt = 1'b0;
         pin_sync_nxt = 1'b0;
      end
   end

   always_ff @(posedge I_CLK) begin
      pin_meta_r <= pin_meta_nxt;
      pin_sync_r <= pin_sync_nxt;
   end

   // reset request decode
   logic por_req;
   logic clear_req;
   logic any_req;

   always_comb begin
      por_req = ~I_RESET_N;
      clear_req = por_req | pin_sync_r | i_lvi_default_reset_req;
      any_req = clear_req | i_wdt_reset_req | i_lvi_reset_req;
   end

   // peripheral bank
   rssf_bank_t bank_r;
   rssf_bank_t bank_nxt;

   always_comb begin
      bank_nxt = bank_r;
      if (any_req) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            bank_nxt[i] = rst_val(i, i_wdt_option, i_package_32pin);
         end
      end else if (i_write.en && int'(i_write.idx) < NUM_REGS) begin
         bank_nxt[i_write.idx] = i_write.data;
      end
   end

   always_ff @(posedge I_CLK) begin
      bank_r <= bank_nxt;
   end

   // source flags and detector settings
   logic wdt_flag_r;
   logic lvi_flag_r;
   logic wdt_flag_nxt;
   logic lvi_flag_nxt;
   rssf_lvi_t lvi_r;
   rssf_lvi_t lvi_nxt;

   always_comb begin
      wdt_flag_nxt = wdt_flag_r;
      lvi_flag_nxt = lvi_flag_r;
      lvi_nxt = lvi_r;
      if (clear_req) begin
         wdt_flag_nxt = 1'b0;
         lvi_flag_nxt = 1'b0;
         lvi_nxt = '0;
      end else if (i_wdt_reset_req || i_lvi_reset_req) begin
         // watchdog and plain detector together set both flags
         if (i_wdt_reset_req) begin
            wdt_flag_nxt = 1'b1;
            lvi_nxt = '0;
         end
         if (i_lvi_reset_req) begin
            lvi_flag_nxt = 1'b1;
         end
      end else begin
         // a read clears both flags; only a reset can set them
         if (i_flags_read) begin
            wdt_flag_nxt = 1'b0;
            lvi_flag_nxt = 1'b0;
         end
         if (i_write.en && int'(i_write.idx) == IDX_LVI_CTRL) begin
            lvi_nxt.control = i_write.data;
         end
         if (i_write.en && int'(i_write.idx) == IDX_LVI_LEVEL) begin
            lvi_nxt.level = i_write.data;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      wdt_flag_r <= wdt_flag_nxt;
      lvi_flag_r <= lvi_flag_nxt;
      lvi_r <= lvi_nxt;
   end

   // reset status, released one edge after the last request drops
   logic in_reset_r;
   logic in_reset_nxt;

   always_comb begin
      in_reset_nxt = any_req;
   end

   always_ff @(posedge I_CLK) begin
      in_reset_r <= in_reset_nxt;
   end

   // outputs straight from flip-flops
   always_comb begin
      o_in_reset = in_reset_r;
      o_regs = bank_r;
      o_lvi = lvi_r;
      o_reset_source_flags = RST_ZERO;
      o_reset_source_flags[FLAG_WDT_BIT] = wdt_flag_r;
      o_reset_source_flags[FLAG_LVI_BIT] = lvi_flag_r;
   end

   // checks
   sequence s_req_then_quiet;
      any_req ##1 !any_req;
   endsequence

   property p_release;
      @(posedge I_CLK) disable iff (!I_RESET_N)
      s_req_then_quiet |-> ##1 (!in_reset_r && $past(in_reset_r, 1));
   endproperty

   chk_release_together: assert property (p_release)
      else $error("reset status not released one edge after last request");

   chk_wdt_enable_value: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      $past(any_req) |-> bank_r[IDX_WDT_ENABLE] == ($past(i_wdt_option) ? 8'h9A : 8'h1A))
      else $error("watchdog enable reset value wrong");

   chk_adc_cfg_value: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      $past(any_req) |-> bank_r[IDX_ADC_CFG_B] == ($past(i_package_32pin) ? 8'h00 : 8'h07))
      else $error("second A/D port configuration reset value wrong");

   chk_async_mode_ctrl: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      $past(any_req) |-> bank_r[IDX_AS_MODE] == 8'h01 && bank_r[IDX_AS_CTRL] == 8'h16)
      else $error("async serial mode or control reset value wrong");

   chk_buffers_baud: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      $past(any_req) |-> bank_r[IDX_RX_BUF] == 8'hFF && bank_r[IDX_TX_BUF] == 8'hFF
         && bank_r[IDX_BAUD_CTRL] == 8'hFF && bank_r[IDX_TW_LOW] == 8'hFF && bank_r[IDX_TW_HIGH] == 8'hFF)
      else $error("buffer, baud or width reset value wrong");

   chk_irq_regs_value: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      $past(any_req) |-> bank_r[IDX_IRQ_MASK+3] == 8'hFF && bank_r[IDX_IRQ_PRIO] == 8'hFF
         && bank_r[IDX_IRQ_REQ+3] == 8'h00 && bank_r[IDX_IRQ_REQ] == 8'h00)
      else $error("interrupt register reset value wrong");

   chk_zero_regs_value: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      $past(any_req) |-> bank_r[IDX_ADC_RES_LO] == 8'h00 && bank_r[IDX_ADC_RES_HI] == 8'h00
         && bank_r[IDX_CLK_OUT_SEL] == 8'h00 && bank_r[IDX_REG_MODE] == 8'h00)
      else $error("cleared register reset value wrong");

   chk_wdt_flag_src: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (i_wdt_reset_req && !clear_req) |=> o_reset_source_flags[FLAG_WDT_BIT]
         && o_reset_source_flags[FLAG_LVI_BIT] == $past(lvi_flag_r || i_lvi_reset_req))
      else $error("watchdog reset did not set its flag or disturbed the other");

   chk_lvi_flag_src: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (i_lvi_reset_req && !clear_req && !i_wdt_reset_req) |=> o_reset_source_flags[FLAG_LVI_BIT]
         && o_reset_source_flags[FLAG_WDT_BIT] == $past(wdt_flag_r) && o_lvi == $past(lvi_r))
      else $error("plain detector reset flag or hold wrong");

   chk_clear_sources: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      clear_req |=> o_reset_source_flags == 8'h00 && o_lvi == '0 ##1 (!$past(any_req) || o_lvi == '0))
      else $error("clearing reset left flags or detector settings");

   chk_read_clears: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (i_flags_read && !any_req) |=> o_reset_source_flags == 8'h00)
      else $error("flag read did not clear the flags");

   // every request shows as reset status one edge later
   chk_in_reset_rise: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      any_req |=> o_in_reset)
      else $error("reset status did not follow a request");

   // a write outside reset lands in its bank entry at the next edge
   chk_write_lands: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (i_write.en && !any_req && int'(i_write.idx) < NUM_REGS)
         |=> o_regs[$past(i_write.idx)] == $past(i_write.data))
      else $error("bank write did not land");

   // indices past the detector registers change nothing
   chk_wide_index_ignored: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (i_write.en && !any_req && int'(i_write.idx) > IDX_LVI_LEVEL) |=> $stable(o_regs) && $stable(o_lvi))
      else $error("write past the last index changed a register");

   // detector settings take software writes only outside reset
   chk_ctrl_write: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (i_write.en && !any_req && int'(i_write.idx) == IDX_LVI_CTRL) |=> o_lvi.control == $past(i_write.data))
      else $error("detector control write did not land");

   chk_level_write: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (i_write.en && !any_req && int'(i_write.idx) == IDX_LVI_LEVEL) |=> o_lvi.level == $past(i_write.data))
      else $error("detector level write did not land");

   // a watchdog reset clears the detector settings even beside a plain detector reset
   chk_wdt_clears_lvi: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      i_wdt_reset_req |=> o_lvi == '0)
      else $error("watchdog reset left detector settings");

   // a read that meets a watchdog request loses: the flag is still set
   chk_read_loses: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      (i_flags_read && i_wdt_reset_req && !clear_req) |=> o_reset_source_flags[FLAG_WDT_BIT])
      else $error("flag read won over a watchdog reset");

   // pin held low through both synchroniser stages: reset shown, flags and settings cleared
   sequence s_pin_held;
      !i_pin_reset_n [*3];
   endsequence

   chk_pin_clears: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      s_pin_held |=> o_in_reset && o_reset_source_flags == 8'h00 && o_lvi == '0)
      else $error("pin reset did not clear flags and settings");

   // one watchdog request between quiet cycles: released one edge later, flag kept
   sequence s_wdt_pulse;
      !any_req ##1 (i_wdt_reset_req && !clear_req) ##1 (!any_req && !i_flags_read);
   endsequence

   chk_wdt_walk: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
      s_wdt_pulse |=> !o_in_reset && o_reset_source_flags[FLAG_WDT_BIT])
      else $error("watchdog walk did not release with its flag set");

endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking testbench for the reset state and source flag block.
// assumes rssf_pkg and rssf_top are compiled first; inputs move on falling edges.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import rssf_pkg::*;

   logic clk, rst_n, pin_n, wdt, low_voltage_detector, lvid, opt, p32, rd;
   rssf_wr_t wr;
   logic in_reset;
   rssf_bank_t regs;
   logic [7:0] flags;
   rssf_lvi_t lvi_set;
   int n_fail, n_tests;

   rssf_top dut (.I_CLK(clk), .I_RESET_N(rst_n), .i_pin_reset_n(pin_n), .i_wdt_reset_req(wdt),
      .i_lvi_reset_req(low_voltage_detector), .i_lvi_default_reset_req(lvid), .i_wdt_option(opt),
      .i_package_32pin(p32), .i_write(wr), .i_flags_read(rd), .o_in_reset(in_reset),
      .o_regs(regs), .o_reset_source_flags(flags), .o_lvi(lvi_set));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // one comparison, counted and reported
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // expected reset value of one bank entry
   function automatic logic [7:0] exp_reg(input int i, input logic o, input logic p);
      case (i)
         IDX_WDT_ENABLE: return o ? RST_WDT_EN_B : RST_WDT_EN_A;
         IDX_ADC_CFG_B: return p ? 8'h00 : 8'h07;
         IDX_RX_BUF, IDX_TX_BUF, IDX_BAUD_CTRL, IDX_TW_LOW, IDX_TW_HIGH: return 8'hFF;
         IDX_AS_MODE: return 8'h01;
         IDX_AS_CTRL: return 8'h16;
         default: return (i >= IDX_IRQ_MASK && i < IDX_IRQ_PRIO + IRQ_GROUP) ? 8'hFF : 8'h00;
      endcase
   endfunction

   // whole bank against its reset values
   task automatic check_bank();
      for (int i = 0; i < NUM_REGS; i++) begin
         check({8'h00, regs[i]}, {8'h00, exp_reg(i, opt, p32)}, $sformatf("bank %0d", i));
      end
   endtask

   // back-to-back writes of one value to every bank and detector entry
   task automatic wr_all(input logic [7:0] d);
      for (int i = 0; i <= IDX_LVI_LEVEL; i++) begin
         @(negedge clk);
         wr = '{1'b1, 6'(i), d};
      end
      @(negedge clk);
      wr.en = 1'b0;
      check({8'h00, regs[IDX_BAUD_CTRL]}, {8'h00, d}, "write bank");
      check(lvi_set, {d, d}, "write detector");
   endtask

   // one reset request of a given source: 0 pin, 1 watchdog, 2 detector, 3 default start, 4 power-on
   task automatic req(input int k);
      @(negedge clk);
      pin_n = (k != 0);
      wdt = (k == 1);
      low_voltage_detector = (k == 2);
      lvid = (k == 3);
      rst_n = (k != 4);
      repeat (4) @(negedge clk);
      check(in_reset, 1'b1, "in reset");
      pin_n = 1'b1;
      wdt = 1'b0;
      low_voltage_detector = 1'b0;
      lvid = 1'b0;
      rst_n = 1'b1;
      repeat ((k == 0) ? 4 : 1) @(negedge clk);
      check(in_reset, 1'b0, "reset released");
   endtask

   // watchdog reset with the other option and package: flag set, detector cleared
   task automatic t_wdt();
      wr_all(8'h5A);
      opt = 1'b1;
      p32 = 1'b1;
      req(1);
      check_bank();
      check(flags, 8'h10, "wdt flags");
      check(lvi_set, 16'h0000, "wdt detector");
      $display("test wdt done");
   endtask

   // plain detector reset: its flag set, watchdog flag and settings held
   task automatic t_lvi();
      wr_all(8'h3C);
      req(2);
      check_bank();
      check(flags, 8'h11, "lvi flags");
      check(lvi_set, 16'h3C3C, "lvi detector");
      @(negedge clk);
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      check(flags, 8'h00, "read clears");
      $display("test lvi and read done");
   endtask

   // pin, default start and power-on resets clear both flags and the settings
   task automatic t_clear();
      int kinds [3] = '{0, 3, 4};
      opt = 1'b0;
      p32 = 1'b0;
      foreach (kinds[j]) begin
         req(2);
         req(1);
         check(flags, 8'h11, "flags before");
         wr_all(8'h42);
         req(kinds[j]);
         check_bank();
         check(flags, 8'h00, "flags cleared");
         check(lvi_set, 16'h0000, "detector cleared");
      end
      $display("test clearing sources done");
   endtask

   // power-on reset: bank at reset values, flags and settings clear
   task automatic t_por();
      check_bank();
      check(flags, 8'h00, "power-on flags");
      check(lvi_set, 16'h0000, "power-on detector");
      $display("test power-on done");
   endtask

   // a watchdog request refuses a write and a flag read; an index past the last one is ignored
   task automatic t_refused();
      @(negedge clk);
      wdt = 1'b1;
      rd = 1'b1;
      wr = '{1'b1, 6'(IDX_BAUD_CTRL), 8'h55};
      @(negedge clk);
      check(in_reset, 1'b1, "refusing request");
      wdt = 1'b0;
      rd = 1'b0;
      wr = '{1'b1, 6'h3F, 8'h55};
      @(negedge clk);
      wr.en = 1'b0;
      check(in_reset, 1'b0, "refusing released");
      check({8'h00, regs[IDX_BAUD_CTRL]}, 16'h00FF, "write in reset");
      check(flags, 8'h10, "read in reset");
      check_bank();
      check(lvi_set, 16'h0000, "wide index");
      $display("test refused requests done");
   endtask

   // verdict and end of run
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      n_fail = 0;
      n_tests = 0;
      rst_n = 1'b0;
      pin_n = 1'b1;
      wdt = 1'b0;
      low_voltage_detector = 1'b0;
      lvid = 1'b0;
      opt = 1'b0;
      p32 = 1'b0;
      rd = 1'b0;
      wr = '0;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      t_por();
      t_wdt();
      t_lvi();
      t_clear();
      t_refused();
      give_verdict();
   end
endmodule
`default_nettype wire
